// ===== rtl/brc_cfg.svh
// Offsets, reset values and timing counts of the buck regulator control
`ifndef BRC_CFG_SVH
`define BRC_CFG_SVH
// ==========================================
// Register map
`define BRC_ADDR_CTRL 8'h00
`define BRC_ADDR_STATUS 8'h04
`define BRC_ADDR_SSCNT 8'h08
`define BRC_CTRL_EN_BIT 0
`define BRC_CTRL_HIGHVAR_BIT 1
`define BRC_CTRL_RST_EN 1'b1
`define BRC_CTRL_RST_HIGHVAR 1'b0
// ==========================================
// Timing
`define BRC_MCLK_KHZ 100000
`define BRC_OSC_KHZ 750
`define BRC_OSC_PER_CYC (`BRC_MCLK_KHZ / `BRC_OSC_KHZ)
`define BRC_SYNC_MIN_KHZ 500
`define BRC_SYNC_MAX_KHZ 1000
`define BRC_SYNC_MINPER_CYC (`BRC_MCLK_KHZ / `BRC_SYNC_MAX_KHZ)
`define BRC_SYNC_MAXPER_CYC (`BRC_MCLK_KHZ / `BRC_SYNC_MIN_KHZ)
`define BRC_SYNC_LOSS_PERIODS 4
`define BRC_SYNC_TO_CYC (`BRC_SYNC_LOSS_PERIODS * `BRC_SYNC_MAXPER_CYC)
`define BRC_DEAD_NS 20
`define BRC_MCLK_NS 10
`define BRC_DEAD_CYC ((`BRC_DEAD_NS + `BRC_MCLK_NS - 1) / `BRC_MCLK_NS)
`define BRC_SS_CYCLES 4096
`define BRC_OC_MAX 4'hF
`define BRC_OV_CYCLES 32
`define BRC_HOLD_CYCLES 16
`define BRC_RST_HOLD_MS 25
`define BRC_RST_HOLD_CYC (`BRC_RST_HOLD_MS * `BRC_MCLK_KHZ)
`endif

// ===== rtl/brc_pkg.sv
// Types shared by the buck regulator control logic
package brc_pkg;
  // ==========================================
  // Sequencer states
  typedef enum logic [1:0] {
    BRC_OFF,
    BRC_SOFT,
    BRC_RUN,
    BRC_HOLD
  } brc_state_t;
  // ==========================================
  // Analog comparator outputs
  typedef struct packed {
    logic ocTrip;
    logic ovTrip;
    logic inWindow;
    logic lockout;
    logic resetLow;
  } brc_sense_t;
endpackage

// ===== rtl/brc_top.sv
// Switching, sequencing, fault and supervisor logic of the buck regulator
`timescale 1ns/100ps
`include "brc_cfg.svh"
module brc_top import brc_pkg::*; #(
  parameter int unsigned RST_HOLD_CYC = `BRC_RST_HOLD_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [31:0] rdData,
  // Control pins
  input wire logic enable,
  input wire logic syncIn,
  input wire logic selHigh,
  input wire logic selLow,
  // Analog comparators
  input wire brc_sense_t sense,
  input wire logic peakTrip,
  input wire logic limitTrip,
  // Power stage
  output logic hsOn,
  output logic lsOn,
  output logic oscRun,
  output logic refOn,
  output logic refFixed,
  output logic [3:0] ssLimit,
  output logic [1:0] levelCode,
  // Regulation-ok open-drain pin and reset output
  output logic regOkOut,
  output logic regOkOeN,
  output logic resetN
);

  // ==========================================
  // Functions
  function automatic logic [1:0] levelDecode(input logic hi, input logic lo,
                                             input logic highVar);
    logic [1:0] code;
    code = 2'h0;
    if (hi) begin
      code = highVar ? 2'h3 : 2'h2;
    end else if (!lo) begin
      code = highVar ? 2'h2 : 2'h1;
    end
    return code;
  endfunction

  function automatic logic [3:0] satStep(input logic [3:0] v, input logic up);
    logic [3:0] r;
    r = v;
    if (up && v != 4'hF) begin
      r = v + 4'h1;
    end else if (!up && v != 4'h0) begin
      r = v - 4'h1;
    end
    return r;
  endfunction

  // ==========================================
  // Registers
  logic swEnable;
  logic highVar;
  brc_state_t state;
  brc_state_t next_state;
  brc_sense_t senseMeta;
  brc_sense_t senseSync;
  logic syncPrev;
  logic [9:0] sinceEdge;
  logic extLocked;
  logic [7:0] phaseCnt;
  logic [11:0] ssCount;
  logic [3:0] ocCount;
  logic [4:0] ovCount;
  logic [3:0] holdCnt;
  logic [1:0] deadCnt;
  logic [21:0] rstCnt;

  // ==========================================
  // Register port decode
  wire selCtrl = addr == `BRC_ADDR_CTRL;
  wire selStatus = addr == `BRC_ADDR_STATUS;
  wire selSs = addr == `BRC_ADDR_SSCNT;
  wire [31:0] statusWord = {17'h0, levelCode, ovCount, ocCount,
                            (state != BRC_OFF), resetN, regOkOeN, extLocked};
  wire [31:0] rdMux = selCtrl ? {30'h0, highVar, swEnable} :
                      selStatus ? statusWord :
                      selSs ? {20'h0, ssCount} : 32'h0;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      swEnable <= `BRC_CTRL_RST_EN;
      highVar <= `BRC_CTRL_RST_HIGHVAR;
    end else if (wrEn && selCtrl) begin
      swEnable <= wrData[`BRC_CTRL_EN_BIT];
      highVar <= wrData[`BRC_CTRL_HIGHVAR_BIT];
    end
  end

  // Read data stand for one cycle only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData <= 32'h0;
    end else begin
      rdData <= rdEn ? rdMux : 32'h0;
    end
  end

  // ==========================================
  // Comparator synchroniser
  // two-flop capture
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      senseMeta <= '0;
      senseSync <= '0;
    end else begin
      senseMeta <= sense;
      senseSync <= senseMeta;
    end
  end

  // ==========================================
  // Switching clock: external lock with internal fallback
  wire running = state != BRC_OFF;
  wire syncRise = syncIn && !syncPrev;
  // Edges faster than 1000 kHz are ignored once locked; the timer lags the edge by one
  wire validEdge = syncRise &&
                   (!extLocked || sinceEdge >= 10'(`BRC_SYNC_MINPER_CYC - 1));
  wire syncLost = sinceEdge == 10'(`BRC_SYNC_TO_CYC);
  wire intWrap = phaseCnt == 8'(`BRC_OSC_PER_CYC - 1);
  // Internal phase keeps counting while locked, so a fallback needs no restart
  wire cycleStart = running && (extLocked ? validEdge : (validEdge || intWrap));

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      syncPrev <= 1'b0;
    end else begin
      syncPrev <= syncIn;
    end
  end

  // idle timer on the sync input
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sinceEdge <= 10'h0;
    end else if (syncRise) begin
      sinceEdge <= 10'h0;
    end else if (!syncLost) begin
      sinceEdge <= sinceEdge + 10'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      extLocked <= 1'b0;
    end else if (!running) begin
      extLocked <= 1'b0;
    end else if (validEdge) begin
      extLocked <= 1'b1;
    end else if (syncLost) begin
      extLocked <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phaseCnt <= 8'h0;
    end else if (!running || cycleStart || intWrap) begin
      phaseCnt <= 8'h0;
    end else begin
      phaseCnt <= phaseCnt + 8'h1;
    end
  end

  // ==========================================
  // Sequencer
  wire enGo = enable && swEnable;
  wire switching = state == BRC_SOFT || state == BRC_RUN;
  wire ssEnd = ssCount == 12'(`BRC_SS_CYCLES - 1);
  wire ocFull = ocCount == `BRC_OC_MAX;
  wire ovFull = ovCount == 5'(`BRC_OV_CYCLES - 1) && senseSync.ovTrip;
  wire holdEnd = holdCnt == 4'(`BRC_HOLD_CYCLES - 1);

  always_comb begin
    next_state = state;
    case (state)
      BRC_OFF: begin
        if (enGo && !senseSync.lockout) begin
          next_state = BRC_SOFT;
        end
      end
      BRC_SOFT: begin
        if (ocFull || (cycleStart && ovFull)) begin
          next_state = BRC_HOLD;
        end else if (cycleStart && ssEnd) begin
          next_state = BRC_RUN;
        end
      end
      BRC_RUN: begin
        if (ocFull || (cycleStart && ovFull)) begin
          next_state = BRC_HOLD;
        end
      end
      BRC_HOLD: begin
        if (cycleStart && holdEnd) begin
          next_state = BRC_SOFT;
        end
      end
      default: begin
        next_state = BRC_OFF;
      end
    endcase
    // reset output is not an input to this path
    if (!enGo || senseSync.lockout) begin
      next_state = BRC_OFF;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= BRC_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ssCount <= 12'h0;
    end else if (state != BRC_SOFT) begin
      ssCount <= 12'h0;
    end else if (cycleStart && !ssEnd) begin
      ssCount <= ssCount + 12'h1;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ocCount <= 4'h0;
    end else if (!switching) begin
      ocCount <= 4'h0;
    end else if (cycleStart) begin
      ocCount <= satStep(ocCount, senseSync.ocTrip);
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ovCount <= 5'h0;
    end else if (!switching) begin
      ovCount <= 5'h0;
    end else if (cycleStart) begin
      ovCount <= senseSync.ovTrip ? ovCount + 5'h1 : 5'h0;
    end
  end

  // 16-cycle off time before a fresh soft-start
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      holdCnt <= 4'h0;
    end else if (state != BRC_HOLD) begin
      holdCnt <= 4'h0;
    end else if (cycleStart) begin
      holdCnt <= holdCnt + 4'h1;
    end
  end

  // ==========================================
  // Switch drive
  // current limit trip ends high-side conduction like the PWM trip
  wire hsTrip = hsOn && (peakTrip || limitTrip) && !cycleStart;
  // Gated on the next state so a fault or shutdown decision never opens a new pulse
  wire nextSwitching = next_state == BRC_SOFT || next_state == BRC_RUN;
  // low side is never released on zero current, so reverse current flows
  wire next_hsOn = nextSwitching && (cycleStart || (hsOn && !hsTrip));
  wire next_lsOn = nextSwitching && !cycleStart && (lsOn || deadCnt == 2'h1);

  // dead time and low side release
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hsOn <= 1'b0;
      lsOn <= 1'b0;
      deadCnt <= 2'h0;
    end else begin
      hsOn <= next_hsOn;
      lsOn <= next_lsOn;
      // A dead-time count left from the last cycle must not turn the low side on
      if (cycleStart) begin
        deadCnt <= 2'h0;
      end else if (hsTrip) begin
        deadCnt <= 2'(`BRC_DEAD_CYC);
      end else if (deadCnt != 2'h0) begin
        deadCnt <= deadCnt - 2'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      oscRun <= 1'b0;
      refOn <= 1'b0;
      refFixed <= 1'b0;
      ssLimit <= 4'h0;
      levelCode <= 2'h0;
    end else begin
      oscRun <= next_state != BRC_OFF;
      refOn <= next_state != BRC_OFF;
      refFixed <= next_state == BRC_RUN;
      ssLimit <= next_state == BRC_RUN ? 4'hF :
                 next_state == BRC_SOFT ? ssCount[11:8] : 4'h0;
      levelCode <= levelDecode(selHigh, selLow, highVar);
    end
  end

  // ==========================================
  // Regulation-ok and supervisor
  // pin pulled low unless enabled and in window
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regOkOut <= 1'b0;
      regOkOeN <= 1'b0;
    end else begin
      regOkOut <= 1'b0;
      regOkOeN <= running && senseSync.inWindow;
    end
  end

  // minimum reset pulse, also held after power-on
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rstCnt <= 22'(RST_HOLD_CYC);
      resetN <= 1'b0;
    end else begin
      if (senseSync.resetLow) begin
        rstCnt <= 22'(RST_HOLD_CYC);
      end else if (rstCnt != 22'h0) begin
        rstCnt <= rstCnt - 22'h1;
      end
      resetN <= !senseSync.resetLow && rstCnt == 22'h0;
    end
  end

  // ==========================================
  // Assertions
  property p_pgOff;
    @(posedge mclk) disable iff (!rstn) !running |=> !regOkOeN;
  endproperty
  a_pgOff: assert property (p_pgOff) else $error("flag released while off");

  property p_syncLost;
    @(posedge mclk) disable iff (!rstn) (extLocked && syncLost && !syncRise) |=> !extLocked;
  endproperty
  a_syncLost: assert property (p_syncLost) else $error("no fallback");

  property p_ocSat;
    @(posedge mclk) disable iff (!rstn)
      (switching && cycleStart && ocCount == 4'h0 && !senseSync.ocTrip) |=> ocCount == 4'h0;
  endproperty
  a_ocSat: assert property (p_ocSat) else $error("counter wrapped");

  property p_ocShut;
    @(posedge mclk) disable iff (!rstn)
      (switching && ocFull && enGo && !senseSync.lockout) |=> state == BRC_HOLD ##1 !hsOn;
  endproperty
  a_ocShut: assert property (p_ocShut) else $error("overcurrent not shut");

  property p_ovShut;
    @(posedge mclk) disable iff (!rstn)
      (switching && cycleStart && ovFull && enGo && !senseSync.lockout) |=> state == BRC_HOLD;
  endproperty
  a_ovShut: assert property (p_ovShut) else $error("overvoltage not shut");

  property p_hsStart;
    @(posedge mclk) disable iff (!rstn) (cycleStart && switching && next_state == state) |=> hsOn;
  endproperty
  a_hsStart: assert property (p_hsStart) else $error("high side late");

  property p_dead;
    @(posedge mclk) disable iff (!rstn) $fell(hsOn) |-> !lsOn ##1 !lsOn;
  endproperty
  a_dead: assert property (p_dead) else $error("dead time short");

  property p_noOverlap;
    @(posedge mclk) disable iff (!rstn) !(hsOn && lsOn);
  endproperty
  a_noOverlap: assert property (p_noOverlap) else $error("shoot through");

  property p_shutdown;
    @(posedge mclk) disable iff (!rstn) !enable |=> !oscRun ##1 (!hsOn && !lsOn);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("active in shutdown");

  property p_lockout;
    @(posedge mclk) disable iff (!rstn) senseSync.lockout |=> state == BRC_OFF;
  endproperty
  a_lockout: assert property (p_lockout) else $error("start under lockout");

  property p_rstLow;
    @(posedge mclk) disable iff (!rstn) $fell(senseSync.resetLow) |=> !resetN [*8];
  endproperty
  a_rstLow: assert property (p_rstLow) else $error("reset pulse short");

  property p_ssDone;
    @(posedge mclk) disable iff (!rstn)
      (state == BRC_SOFT && next_state == BRC_RUN) |=> refFixed;
  endproperty
  a_ssDone: assert property (p_ssDone) else $error("reference not fixed");

  c_lock: cover property (@(posedge mclk) disable iff (!rstn) $rose(extLocked));
  c_hold: cover property (@(posedge mclk) disable iff (!rstn) state == BRC_HOLD);
  c_run: cover property (@(posedge mclk) disable iff (!rstn) $rose(refFixed));
  c_rst: cover property (@(posedge mclk) disable iff (!rstn) $rose(resetN));

endmodule

// ===== test/brc_load_model.sv
// Inductor current and select-pin model on the far side of the regulator control
`timescale 1ns/100ps
module brc_load_model (
  // Clock
  input wire logic mclk,
  // Switch drive and scenario knobs
  input wire logic hsOn,
  input wire logic [7:0] onTime,
  input wire logic [1:0] pick,
  // Comparator and select pins
  output logic peakTrip,
  output logic selHigh,
  output logic selLow
);
  logic [7:0] ramp = 8'h00;
  // ==========================================
  // Inductor current
  // Current only builds while the high side conducts; it is gone once the switch is off
  always @(posedge mclk) begin
    ramp <= hsOn ? ramp + 8'h01 : 8'h00;
  end
  assign peakTrip = hsOn && (ramp >= onTime);
  // ==========================================
  // Three-level select pin
  // high open low
  assign selHigh = (pick == 2'h2);
  assign selLow = (pick == 2'h0);
endmodule

// ===== test/tb_brc_top.sv
// Self-checking bench of the buck regulator control logic
`timescale 1ns/100ps
module tb_brc_top import brc_pkg::*;;
  localparam int HOLD = 20;
  localparam int PER = 133;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wrData = 32'h0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic enable = 1'b0;
  logic syncIn = 1'b0;
  logic limitTrip = 1'b0;
  brc_sense_t sense = '0;
  logic [7:0] onTime = 8'h10;
  logic [1:0] pick = 2'h1;
  logic [31:0] rdData;
  logic [3:0] ssLimit;
  logic [1:0] levelCode;
  logic peakTrip, selHigh, selLow, hsOn, lsOn, oscRun, refOn, refFixed;
  logic regOkOut, regOkOeN, resetN;
  int syncPer = 0;
  int syncCnt = 0;
  int seed = 32'h9331;
  int numErrors = 0;
  int nCompared = 0;
  int n, a, b, c;
  logic [31:0] v;

  brc_top #(.RST_HOLD_CYC(HOLD)) uut (
    .mclk, .rstn, .addr, .wrData, .wrEn, .rdEn, .rdData, .enable, .syncIn, .selHigh,
    .selLow, .sense, .peakTrip, .limitTrip, .hsOn, .lsOn, .oscRun, .refOn, .refFixed,
    .ssLimit, .levelCode, .regOkOut, .regOkOeN, .resetN
  );
  brc_load_model load (.mclk, .hsOn, .onTime, .pick, .peakTrip, .selHigh, .selLow);

  always #5 mclk = ~mclk;
  // External clock source, high for a third of each period
  always @(posedge mclk) begin
    syncCnt <= (syncCnt + 1 >= syncPer) ? 0 : syncCnt + 1;
    syncIn <= (syncPer != 0) && (syncCnt < syncPer / 3);
  end

  // ==========================================
  // Checking and bus tasks
  task automatic close_out();
    $display("counts: %0d compared, %0d wrong", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    addr <= ad;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge mclk);
    wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge mclk);
    addr <= ad;
    rdEn <= 1'b1;
    @(posedge mclk);
    rdEn <= 1'b0;
    #1;
    d = rdData;
  endtask
  // Waits for hsOn (0), lsOn (1) or resetN (2) to reach a level; a hang ends the run
  task automatic waitFor(input int which, input logic lvl, input int bound, output int cyc);
    cyc = 0;
    while ((which == 0 ? hsOn : which == 1 ? lsOn : resetN) !== lvl) begin
      @(posedge mclk);
      #1;
      cyc++;
      if (cyc > bound) begin
        numErrors++;
        $display("wrong value at %0t: wait ran out, seen %h expected %h", $time, !lvl, lvl);
        close_out();
      end
    end
  endtask
  task automatic rise();
    waitFor(0, 1'b0, 300, n);
    waitFor(0, 1'b1, 300, n);
  endtask
  // Called just after hsOn rises: on time, dead time, rest of cycle
  task automatic meas(output int per);
    waitFor(0, 1'b0, 200, a);
    waitFor(1, 1'b1, 10, b);
    waitFor(0, 1'b1, 200, c);
    per = a + b + c;
  endtask
  // Longest silent stretch, pulses before it, and the final silent run
  task automatic gapRun(output int mx, output int pc, output int cur);
    logic prev;
    mx = 0;
    pc = 0;
    cur = 0;
    prev = hsOn;
    repeat (8000) begin
      @(posedge mclk);
      #1;
      if (hsOn && !prev && mx < 200) pc++;
      prev = hsOn;
      cur = hsOn ? 0 : cur + 1;
      if (cur > mx) mx = cur;
      // Fault removed once the output is off, so the restart can be seen
      if (cur == 200) sense <= '0;
    end
  endtask
  function automatic logic [1:0] lvlExp(input logic hv, input logic [1:0] p);
    if (p == 2'h0) return 2'h0;
    return hv ? p + 2'h1 : p;
  endfunction

  // ==========================================
  // Scenarios
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    #1;
    chk({hsOn, lsOn, oscRun, refOn, resetN}, 0);
    waitFor(2, 1'b1, HOLD + 8, n);
    chk(n >= HOLD, 1);
    rd(8'h00, v);
    chk(v, 1);
    wr(8'h08, 32'hFFF);
    rd(8'h08, v);
    chk(v, 0);
    rd(8'h0C, v);
    chk(v, 0);
    $display("test done: reset and registers");
    for (int k = 0; k < 6; k++) begin
      wr(8'h00, {30'h0, k[0], 1'b1});
      pick <= 2'(k / 2);
      repeat (3) @(posedge mclk);
      #1;
      chk(levelCode, lvlExp(k[0], 2'(k / 2)));
    end
    wr(8'h00, 32'h1);
    $display("test done: level select");
    sense.lockout <= 1'b1;
    repeat (5) @(posedge mclk);
    enable <= 1'b1;
    repeat (200) @(posedge mclk);
    #1;
    chk({oscRun, hsOn, lsOn}, 0);
    sense.lockout <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    chk({oscRun, refOn, refFixed, ssLimit}, 7'h60);
    waitFor(0, 1'b1, PER + 10, n);
    onTime <= 8'hFF;
    repeat (6) @(posedge mclk);
    limitTrip <= 1'b1;
    waitFor(0, 1'b0, 2, n);
    limitTrip <= 1'b0;
    chk(hsOn, 0);
    waitFor(0, 1'b1, 200, n);
    for (int k = 0; k < 6; k++) begin
      onTime <= 8'(5 + $unsigned($random(seed)) % 50);
      meas(n);
      chk(a, onTime + 1);
      chk(b, 2);
      chk(lsOn, 0);
      chk(n, PER);
    end
    $display("test done: start and switching");
    sense.resetLow <= 1'b1;
    waitFor(2, 1'b0, 5, n);
    rise();
    sense.resetLow <= 1'b0;
    waitFor(2, 1'b1, HOLD + 8, n);
    chk(n >= HOLD, 1);
    $display("test done: supervisor");
    sense.ocTrip <= 1'b1;
    repeat (3) rise();
    rd(8'h04, v);
    chk(v[7:4], 3);
    sense.ocTrip <= 1'b0;
    repeat (5) rise();
    rd(8'h04, v);
    chk(v[7:4], 0);
    sense.ocTrip <= 1'b1;
    gapRun(n, a, b);
    chk(a == 14 || a == 15, 1);
    chk(n >= 15 * PER && n <= 18 * PER, 1);
    chk(b < 200, 1);
    rd(8'h08, v);
    chk(v[11:0] <= (8000 - 15 * PER) / PER, 1);
    rise();
    sense.ovTrip <= 1'b1;
    gapRun(n, a, b);
    chk(a == 31 || a == 32, 1);
    chk(n >= 15 * PER && n <= 18 * PER, 1);
    chk(b < 200, 1);
    $display("test done: faults");
    onTime <= 8'h0A;
    syncPer <= 100;
    repeat (3) rise();
    meas(n);
    chk(n, 100);
    rd(8'h04, v);
    chk(v[0], 1);
    syncPer <= 0;
    repeat (1000) @(posedge mclk);
    rd(8'h04, v);
    chk(v[0], 0);
    rise();
    meas(n);
    chk(n, PER);
    $display("test done: synchronisation");
    for (int k = 0; k < 8; k++) begin
      sense.inWindow <= 1'($random(seed));
      repeat (4) @(posedge mclk);
      #1;
      chk(regOkOeN, sense.inWindow);
      chk(regOkOut, 0);
    end
    sense.inWindow <= 1'b1;
    wr(8'h00, 32'h0);
    repeat (3) @(posedge mclk);
    #1;
    chk({oscRun, refOn, regOkOeN}, 0);
    wr(8'h00, 32'h1);
    repeat (3) @(posedge mclk);
    #1;
    chk(oscRun, 1);
    enable <= 1'b0;
    repeat (300) @(posedge mclk);
    #1;
    chk({oscRun, refOn, hsOn, lsOn, regOkOeN, ssLimit}, 0);
    $display("test done: regulation flag and shutdown");
    close_out();
  end
endmodule
